/* File: core/cmp_vref_pkg.sv */
// Register map, field positions, reset values and mode codes of the comparator and reference control.
package cmp_vref_pkg;
   // ----------------------------------------------------------------
   // Register offsets.
   // ----------------------------------------------------------------
   localparam logic [7:0] ADDR_PORT_A     = 8'h05;
   localparam logic [7:0] ADDR_IRQ_CTRL   = 8'h0b;
   localparam logic [7:0] ADDR_PERIPH_FLG = 8'h0c;
   localparam logic [7:0] ADDR_CMP_CTRL   = 8'h1f;
   localparam logic [7:0] ADDR_PORT_A_DIR = 8'h85;
   localparam logic [7:0] ADDR_PERIPH_EN  = 8'h8c;
   localparam logic [7:0] ADDR_REF_CTRL   = 8'h9f;

   // ----------------------------------------------------------------
   // Field positions.
   // ----------------------------------------------------------------
   localparam int GLOBAL_EN_BIT   = 7;
   localparam int PERIPH_EN_BIT   = 6;
   localparam int CHANGE_FLAG_BIT = 6;
   localparam int CHANGE_EN_BIT   = 6;
   localparam int SECOND_OUT_BIT  = 7;
   localparam int FIRST_OUT_BIT   = 6;
   localparam int SECOND_INV_BIT  = 5;
   localparam int FIRST_INV_BIT   = 4;
   localparam int INPUT_SW_BIT    = 3;
   localparam int REF_EN_BIT      = 7;
   localparam int REF_PIN_BIT     = 6;
   localparam int REF_RANGE_BIT   = 5;
   localparam int FIRST_PIN       = 3;
   localparam int SECOND_PIN      = 4;
   localparam int REF_PIN         = 2;

   // ----------------------------------------------------------------
   // Mode codes, reset values and ladder figures.
   // ----------------------------------------------------------------
   localparam logic [2:0] MODE_RESET     = 3'h0;
   localparam logic [2:0] MODE_OUT_A     = 3'h1;
   localparam logic [2:0] MODE_OUT_B     = 3'h6;
   localparam logic [2:0] MODE_OFF       = 3'h7;
   localparam logic [7:0] CMP_CTRL_RST   = 8'h00;
   localparam logic [7:0] PORT_DIR_RST   = 8'hff;
   localparam logic [7:0] REF_CTRL_RST   = 8'h00;
   localparam logic [7:0] ANALOG_FULL    = 8'h0f;
   localparam logic [7:0] ANALOG_OUTMODE = 8'h07;
   localparam logic [7:0] ANALOG_NONE    = 8'h00;
   localparam logic [5:0] LOW_RANGE_DEN  = 6'd24;
   localparam logic [5:0] HIGH_RANGE_DEN = 6'd32;
   localparam logic [5:0] HIGH_RANGE_OFS = 6'd8;
endpackage

/* File: core/comparator_vref_control.sv */
// Digital control of a two-comparator unit and its resistor-ladder voltage reference.
//
// Contract
// - Comparator result bits in the control register are read-only.
// - Modes 110 and 001 route comparator outputs onto the two port pins.
// - Port direction bits still enable the drivers of those pins.
// - Port reads return zero for pins that the mode makes analog.
// - Any change of either comparator output sets the change flag.
// - Writing 0 clears the change flag, writing 1 sets it.
// - Interrupt request needs change, peripheral and global enables all set.
// - The flag is set regardless of the interrupt enables.
// - A change landing on a control register access may not set the flag.
// - Any control register access ends the pending mismatch.
// - A lasting mismatch keeps setting the flag after software clears it.
// - Comparators stay active in sleep; an enabled change wakes the device.
// - Mode 111 turns both comparators off.
// - Wake from sleep leaves the control register unchanged.
// - Reset loads the control register with zero: reset mode, comparators off.
// - Reference bit 7 powers the ladder, bit 6 connects it to its pin.
// - Reference bit 5 selects low range; bit 4 reads as zero.
// - Level gives level/24 in low range, 1/4 plus level/32 in high range.
// - Sixteen levels per range, selected by the 4-bit field.
// - Reset clears the whole reference control: off, disconnected, high range.
//
// The strobed register port was decided locally.
`timescale 1ns/100ps
module comparator_vref_control
   import cmp_vref_pkg::*;
#(
   parameter int PORT_W = 8                    // Port A width.
)(
   input  wire logic              clk,                    // System clock, 100 MHz.
   input  wire logic              sys_rst,                // Asynchronous reset, active high.
   input  wire logic [7:0]        reg_addr,               // Register address.
   input  wire logic [7:0]        reg_wdata,              // Register write data.
   input  wire logic              reg_wr,                 // Write strobe.
   input  wire logic              reg_rd,                 // Read strobe.
   output logic      [7:0]        reg_rdata,              // Read data, one cycle after the strobe.
   input  wire logic              first_compare_raw,      // Raw first comparator output.
   input  wire logic              second_compare_raw,     // Raw second comparator output.
   input  wire logic [PORT_W-1:0] port_a_pin_in,          // Port A pin levels.
   output logic      [PORT_W-1:0] port_a_out,             // Port A output levels.
   output logic      [PORT_W-1:0] port_a_oe,              // Port A driver enables, high drives.
   output logic      [1:0]        compare_power_en,       // Comparator power, bit 0 first.
   output logic      [2:0]        comparator_mode_sel,    // Mode field towards the analog switches.
   output logic                   compare_input_switch,   // Input switch towards the analog switches.
   output logic                   reference_power_en,     // Ladder powered.
   output logic                   reference_pin_out_en,   // Ladder tapped onto its pin.
   output logic                   reference_low_range,    // Low range selected.
   output logic      [3:0]        reference_level_sel,    // Ladder tap.
   output logic      [5:0]        reference_num,          // Reference fraction numerator.
   output logic      [5:0]        reference_den,          // Reference fraction denominator.
   output logic                   irq_request,            // Interrupt request.
   output logic                   wake_request            // Wake from sleep request.
);

   // ----------------------------------------------------------------
   // Register state.
   // ----------------------------------------------------------------
   logic [2:0]        mode_q;
   logic              input_sw_q;
   logic              first_inv_q;
   logic              second_inv_q;
   logic [1:0]        result_q;
   logic [1:0]        copy_q;
   logic              change_flag_q;
   logic              change_flag_d;
   logic              change_en_q;
   logic              periph_en_q;
   logic              global_en_q;
   logic [PORT_W-1:0] port_latch_q;
   logic [PORT_W-1:0] port_dir_q;
   logic              ref_en_q;
   logic              ref_pin_q;
   logic              ref_range_q;
   logic [3:0]        ref_level_q;
   logic [7:0]        rdata_d;
   logic [7:0]        analog_mask;
   logic              cmp_access;
   logic              mismatch;
   logic              out_mode;
   logic              cmp_on;

   // Decodes shared by several processes.
   assign cmp_access = (reg_wr || reg_rd) && (reg_addr == ADDR_CMP_CTRL);
   assign mismatch   = (result_q != copy_q);
   assign out_mode   = (mode_q == MODE_OUT_A) || (mode_q == MODE_OUT_B);
   assign cmp_on     = (mode_q != MODE_OFF) && (mode_q != MODE_RESET);

   // Pins that the current mode hands to the analog side; the reference pin joins while connected.
   always_comb begin
      if (mode_q == MODE_OFF) begin
         analog_mask = ANALOG_NONE;
      end else if (out_mode) begin
         analog_mask = ANALOG_OUTMODE;
      end else begin
         analog_mask = ANALOG_FULL;
      end
      if (ref_pin_q) begin
         analog_mask[REF_PIN] = 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Comparator control register.
   // ----------------------------------------------------------------
   // Only the mode, invert and switch bits are writable; reset forces mode zero.
   // Sleep has no input here, so nothing but a write or reset touches these bits.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q       <= CMP_CTRL_RST[2:0];
         input_sw_q   <= CMP_CTRL_RST[INPUT_SW_BIT];
         first_inv_q  <= CMP_CTRL_RST[FIRST_INV_BIT];
         second_inv_q <= CMP_CTRL_RST[SECOND_INV_BIT];
      end else if (reg_wr && (reg_addr == ADDR_CMP_CTRL)) begin
         mode_q       <= reg_wdata[2:0];
         input_sw_q   <= reg_wdata[INPUT_SW_BIT];
         first_inv_q  <= reg_wdata[FIRST_INV_BIT];
         second_inv_q <= reg_wdata[SECOND_INV_BIT];
      end
   end

   // Results follow the comparators only; a powered-down pair reads as zero. Writes never reach them.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         result_q <= 2'b00;
      end else if (cmp_on) begin
         result_q <= {second_compare_raw ^ second_inv_q, first_compare_raw ^ first_inv_q};
      end else begin
         result_q <= 2'b00;
      end
   end

   // Copy of the results taken at every control register access; this is what ends a mismatch.
   // A change arriving in the access cycle is absorbed into the copy and never flagged.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         copy_q <= 2'b00;
      end else if (cmp_access) begin
         copy_q <= result_q;
      end
   end

   // ----------------------------------------------------------------
   // Change flag and interrupt enables.
   // ----------------------------------------------------------------
   // Hardware set wins over a software clear in the same cycle.
   always_comb begin
      change_flag_d = change_flag_q;
      if (reg_wr && (reg_addr == ADDR_PERIPH_FLG)) begin
         change_flag_d = reg_wdata[CHANGE_FLAG_BIT];
      end
      if (mismatch && !cmp_access) begin
         change_flag_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         change_flag_q <= 1'b0;
      end else begin
         change_flag_q <= change_flag_d;
      end
   end

   // Enable bits; the remaining bits of these registers belong to other units.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         change_en_q <= 1'b0;
         periph_en_q <= 1'b0;
         global_en_q <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == ADDR_PERIPH_EN)) begin
            change_en_q <= reg_wdata[CHANGE_EN_BIT];
         end
         if (reg_wr && (reg_addr == ADDR_IRQ_CTRL)) begin
            periph_en_q <= reg_wdata[PERIPH_EN_BIT];
            global_en_q <= reg_wdata[GLOBAL_EN_BIT];
         end
      end
   end

   // Request and wake; wake ignores the global enable so a sleeping core still resumes.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         irq_request  <= 1'b0;
         wake_request <= 1'b0;
      end else begin
         irq_request  <= change_flag_q && change_en_q && periph_en_q && global_en_q;
         wake_request <= change_flag_q && change_en_q && periph_en_q;
      end
   end

   // ----------------------------------------------------------------
   // Port A latch, direction and output multiplexing.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_latch_q <= '0;
         port_dir_q   <= PORT_DIR_RST[PORT_W-1:0];
      end else begin
         if (reg_wr && (reg_addr == ADDR_PORT_A)) begin
            port_latch_q <= reg_wdata[PORT_W-1:0];
         end
         if (reg_wr && (reg_addr == ADDR_PORT_A_DIR)) begin
            port_dir_q <= reg_wdata[PORT_W-1:0];
         end
      end
   end

   // The pin mux adds one register stage, the price of driving every output from a flip-flop.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_a_out <= '0;
         port_a_oe  <= '0;
      end else begin
         port_a_out <= port_latch_q;
         port_a_oe  <= ~port_dir_q;
         if (out_mode) begin
            port_a_out[FIRST_PIN]  <= result_q[0];
            port_a_out[SECOND_PIN] <= result_q[1];
         end
         if (ref_pin_q) begin
            port_a_oe[REF_PIN] <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Reference control and ladder fraction.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ref_en_q    <= REF_CTRL_RST[REF_EN_BIT];
         ref_pin_q   <= REF_CTRL_RST[REF_PIN_BIT];
         ref_range_q <= REF_CTRL_RST[REF_RANGE_BIT];
         ref_level_q <= REF_CTRL_RST[3:0];
      end else if (reg_wr && (reg_addr == ADDR_REF_CTRL)) begin
         ref_en_q    <= reg_wdata[REF_EN_BIT];
         ref_pin_q   <= reg_wdata[REF_PIN_BIT];
         ref_range_q <= reg_wdata[REF_RANGE_BIT];
         ref_level_q <= reg_wdata[3:0];
      end
   end

   // Registered analog-side controls and the fraction of supply that the ladder should present.
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         compare_power_en     <= 2'b00;
         comparator_mode_sel  <= CMP_CTRL_RST[2:0];
         compare_input_switch <= 1'b0;
         reference_power_en   <= 1'b0;
         reference_pin_out_en <= 1'b0;
         reference_low_range  <= 1'b0;
         reference_level_sel  <= 4'h0;
         reference_num        <= HIGH_RANGE_OFS;
         reference_den        <= HIGH_RANGE_DEN;
      end else begin
         compare_power_en     <= {cmp_on, cmp_on};
         comparator_mode_sel  <= mode_q;
         compare_input_switch <= input_sw_q;
         reference_power_en   <= ref_en_q;
         reference_pin_out_en <= ref_pin_q;
         reference_low_range  <= ref_range_q;
         reference_level_sel  <= ref_level_q;
         if (ref_range_q) begin
            reference_num <= {2'b00, ref_level_q};
            reference_den <= LOW_RANGE_DEN;
         end else begin
            reference_num <= HIGH_RANGE_OFS + {2'b00, ref_level_q};
            reference_den <= HIGH_RANGE_DEN;
         end
      end
   end

   // ----------------------------------------------------------------
   // Read path.
   // ----------------------------------------------------------------
   // Unimplemented bits and unmapped addresses read as zero.
   always_comb begin
      rdata_d = 8'h00;
      case (reg_addr)
         ADDR_CMP_CTRL: begin
            rdata_d = {result_q[1], result_q[0], second_inv_q, first_inv_q, input_sw_q, mode_q};
         end
         ADDR_PERIPH_FLG: begin
            rdata_d[CHANGE_FLAG_BIT] = change_flag_q;
         end
         ADDR_PERIPH_EN: begin
            rdata_d[CHANGE_EN_BIT] = change_en_q;
         end
         ADDR_IRQ_CTRL: begin
            rdata_d[PERIPH_EN_BIT] = periph_en_q;
            rdata_d[GLOBAL_EN_BIT] = global_en_q;
         end
         ADDR_PORT_A: begin
            rdata_d[PORT_W-1:0] = port_a_pin_in & ~analog_mask[PORT_W-1:0];
         end
         ADDR_PORT_A_DIR: begin
            rdata_d[PORT_W-1:0] = port_dir_q;
         end
         ADDR_REF_CTRL: begin
            rdata_d = {ref_en_q, ref_pin_q, ref_range_q, 1'b0, ref_level_q};
         end
         default: begin
            rdata_d = 8'h00;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= rdata_d;
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------------------------------
   // Assertions.
   // ----------------------------------------------------------------
   property p_result_read;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_CMP_CTRL) |=> (reg_rdata[7:6] == $past(result_q));
   endproperty
   a_result_read: assert property (p_result_read) else $error("result bits read wrong");

   property p_pin_mux;
      @(posedge clk) disable iff (sys_rst)
      (mode_q == MODE_OUT_B || mode_q == MODE_OUT_A) |=>
         (port_a_out[FIRST_PIN] == $past(result_q[0]) && port_a_out[SECOND_PIN] == $past(result_q[1]));
   endproperty
   a_pin_mux: assert property (p_pin_mux) else $error("comparator not on pins");

   property p_dir_oe;
      @(posedge clk) disable iff (sys_rst)
      out_mode |=> (port_a_oe[SECOND_PIN] == !$past(port_dir_q[SECOND_PIN]));
   endproperty
   a_dir_oe: assert property (p_dir_oe) else $error("direction ignored in output mode");

   property p_analog_zero;
      @(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == ADDR_PORT_A) |=> ((reg_rdata & $past(analog_mask)) == 8'h00);
   endproperty
   a_analog_zero: assert property (p_analog_zero) else $error("analog pin read nonzero");

   property p_flag_set;
      @(posedge clk) disable iff (sys_rst)
      (mismatch && !cmp_access) |=> change_flag_q;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("mismatch did not set flag");

   property p_flag_clear;
      @(posedge clk) disable iff (sys_rst)
      (reg_wr && reg_addr == ADDR_PERIPH_FLG && !reg_wdata[CHANGE_FLAG_BIT] && !mismatch) |=> !change_flag_q;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear lost");

   property p_irq_gate;
      @(posedge clk) disable iff (sys_rst)
      irq_request |-> $past(change_flag_q && change_en_q && periph_en_q && global_en_q);
   endproperty
   a_irq_gate: assert property (p_irq_gate) else $error("request without all enables");

   property p_access_ends;
      @(posedge clk) disable iff (sys_rst)
      cmp_access |=> (copy_q == $past(result_q));
   endproperty
   a_access_ends: assert property (p_access_ends) else $error("access did not take copy");

   property p_off_mode;
      @(posedge clk) disable iff (sys_rst)
      (mode_q == MODE_OFF) |=> (compare_power_en == 2'b00) ##1 (result_q == 2'b00 || mode_q != MODE_OFF);
   endproperty
   a_off_mode: assert property (p_off_mode) else $error("comparators on in off mode");

   property p_low_range;
      @(posedge clk) disable iff (sys_rst)
      ref_range_q |=> (reference_den == LOW_RANGE_DEN && reference_num == {2'b00, $past(ref_level_q)});
   endproperty
   a_low_range: assert property (p_low_range) else $error("low range fraction wrong");

endmodule

/* File: verif/comparator_vref_control_bench.sv */
// Self-checking bench of the comparator and reference control block.
`timescale 1ns/100ps
module comparator_vref_control_bench;
   import cmp_vref_pkg::*;
   logic       clk = 1'b0;
   logic       sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, pin_in = 8'h00;
   logic       reg_wr = 1'b0, reg_rd = 1'b0, raw1 = 1'b0, raw2 = 1'b0;
   logic [7:0] reg_rdata, port_out, port_oe, d, v;
   logic [1:0] pwr;
   logic [2:0] mode;
   logic [3:0] lvl;
   logic [5:0] num, den;
   logic       sw, ref_en, ref_pin, ref_low, irq, wake;
   int         bad_count = 0;
   int         checks_done = 0;

   // ----------------------------------------------------------------
   // Clock, device and watchdog.
   // ----------------------------------------------------------------
   always #5 clk = ~clk;
   comparator_vref_control #(.PORT_W(8)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .first_compare_raw(raw1), .second_compare_raw(raw2), .port_a_pin_in(pin_in),
      .port_a_out(port_out), .port_a_oe(port_oe), .compare_power_en(pwr), .comparator_mode_sel(mode),
      .compare_input_switch(sw), .reference_power_en(ref_en), .reference_pin_out_en(ref_pin),
      .reference_low_range(ref_low), .reference_level_sel(lvl), .reference_num(num),
      .reference_den(den), .irq_request(irq), .wake_request(wake));
   // The run needs a few hundred cycles; the limit leaves wide margin.
   initial begin
      #200000;
      bad_count++;
      summarize();
   end

   // ----------------------------------------------------------------
   // Bus tasks, expectation and comparison.
   // ----------------------------------------------------------------
   task automatic wr(input logic [7:0] a, input logic [7:0] w);
      @(posedge clk);
      reg_addr <= a; reg_wdata <= w; reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample just after that edge.
   task automatic rd(input logic [7:0] a, output logic [7:0] r);
      @(posedge clk);
      reg_addr <= a; reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 r = reg_rdata;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   function automatic logic [15:0] frac(input logic [7:0] c);
      return c[5] ? {4'h0, 2'b00, c[3:0], 6'd24} : {4'h0, 6'(6'd8 + c[3:0]), 6'd32};
   endfunction
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Tests.
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h0ad8));
      repeat (3) @(posedge clk);
      sys_rst <= 1'b0;
      rd(ADDR_CMP_CTRL, d);   chk(d, 8'h00);
      rd(ADDR_REF_CTRL, d);   chk(d, 8'h00);
      rd(ADDR_PORT_A_DIR, d); chk(d, 8'hff);
      rd(8'h40, d);           chk(d, 8'h00);
      chk(pwr, 2'b00);
      $display("test reset done");
      // Result bits ignore writes; a live change shows through them.
      wr(ADDR_CMP_CTRL, 8'hc2); rd(ADDR_CMP_CTRL, d); chk(d, 8'h02);
      raw1 <= 1'b1; cyc(4);
      rd(ADDR_PERIPH_FLG, d); chk(d, 8'h40);
      chk(irq, 1'b0);
      wr(ADDR_PERIPH_FLG, 8'h00); cyc(2);
      rd(ADDR_PERIPH_FLG, d); chk(d, 8'h40);
      rd(ADDR_CMP_CTRL, d);   chk(d, 8'h42);
      wr(ADDR_PERIPH_FLG, 8'h00); cyc(2);
      rd(ADDR_PERIPH_FLG, d); chk(d, 8'h00);
      raw2 <= 1'b1; cyc(4);
      rd(ADDR_PERIPH_FLG, d); chk(d, 8'h40);
      rd(ADDR_CMP_CTRL, d);   chk(d, 8'hc2);
      // A change landing in the cycle of a control read goes into the copy and raises nothing.
      wr(ADDR_PERIPH_FLG, 8'h00); raw1 <= 1'b0;
      rd(ADDR_CMP_CTRL, d); chk(d, 8'h82);
      cyc(2);
      rd(ADDR_PERIPH_FLG, d); chk(d, 8'h00);
      $display("test change flag done");
      // Every combination of the three enables, with the flag raised by software.
      wr(ADDR_PERIPH_FLG, 8'h00); wr(ADDR_PERIPH_FLG, 8'h40);
      for (int e = 0; e < 8; e++) begin
         wr(ADDR_PERIPH_EN, {1'b0, e[0], 6'h00});
         wr(ADDR_IRQ_CTRL, {e[2], e[1], 6'h00});
         cyc(3);
         chk(irq, e == 7);
         chk(wake, e[0] & e[1]);
      end
      wr(ADDR_PERIPH_FLG, 8'h00); cyc(2);
      chk(irq, 1'b0);
      $display("test enables done");
      // Output modes: pins 3 and 4 carry results, direction still gates drivers.
      for (int i = 0; i < 2; i++) begin
         raw1 <= 1'b0; raw2 <= 1'b0;
         wr(ADDR_CMP_CTRL, {4'h1, i[0], i ? MODE_OUT_B : MODE_OUT_A});
         wr(ADDR_PORT_A_DIR, 8'he7);
         v = 8'($urandom); wr(ADDR_PORT_A, v);
         pin_in <= 8'($urandom);
         cyc(3);
         chk(port_out, (v & 8'he7) | 8'h08);
         chk({pwr, mode, sw}, {2'b11, i ? MODE_OUT_B : MODE_OUT_A, i[0]});
         chk(port_oe, 8'h18);
         rd(ADDR_PORT_A, d); chk(d, pin_in & 8'hf8);
      end
      wr(ADDR_CMP_CTRL, {5'h00, MODE_OFF}); cyc(3);
      chk(pwr, 2'b00);
      rd(ADDR_CMP_CTRL, d); chk(d, 8'h07);
      $display("test port pins done");
      // Random reference settings, bit 4 included, with the top level forced in both ranges.
      // All pins are outputs here, so a connected reference must still take its pin's driver away.
      wr(ADDR_PORT_A_DIR, 8'h00);
      for (int i = 0; i < 10; i++) begin
         v = (i < 2) ? (i ? 8'hff : 8'hcf) : 8'($urandom);
         wr(ADDR_REF_CTRL, v); cyc(3);
         rd(ADDR_REF_CTRL, d); chk(d, v & 8'hef);
         chk({ref_en, ref_pin, ref_low, lvl}, {v[7:5], v[3:0]});
         chk({num, den}, frac(v));
         chk(port_oe, v[6] ? 8'hfb : 8'hff);
         rd(ADDR_PORT_A, d); chk(d, pin_in & (v[6] ? 8'hfb : 8'hff));
      end
      $display("test reference done");
      // Reset in mid-run clears both control registers.
      @(posedge clk);
      sys_rst <= 1'b1;
      @(posedge clk);
      sys_rst <= 1'b0;
      rd(ADDR_CMP_CTRL, d); chk(d, 8'h00);
      rd(ADDR_REF_CTRL, d); chk(d, 8'h00);
      chk({num, den}, {6'd8, 6'd32});
      $display("test second reset done");
      summarize();
   end
endmodule
